// [src/sdfb_pkg.sv]
// Constants, field layouts and carrier types for the device status flag bank.
package sdfb_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_SUMMARY = 8'h01;
  localparam logic [7:0] ADDR_SUPPLY  = 8'h02;
  localparam logic [7:0] ADDR_MEMORY  = 8'h03;
  localparam logic [7:0] ADDR_LINK    = 8'h04;
  // Summary register fields.
  localparam int SUM_SIGPROC = 7;
  localparam int SUM_LINK    = 5;
  localparam int SUM_MEMTEMP = 4;
  localparam int SUM_SUPPLY  = 3;
  localparam int SUM_TEST    = 2;
  localparam int SUM_RESET   = 1;
  localparam int SUM_INIT    = 0;
  // Supply register fields.
  localparam int SUP_UNDERVOLT = 7;
  localparam int SUP_ANALOG    = 3;
  localparam int SUP_DIGITAL   = 2;
  localparam int SUP_OTP       = 1;
  localparam int SUP_SEAL      = 0;
  // Memory register fields.
  localparam int MEM_FACTORY_OTP = 7;
  localparam int MEM_USER_OTP    = 6;
  localparam int MEM_USER_ARRAY  = 5;
  localparam int MEM_WRITE_ACT   = 4;
  localparam int MEM_TEMP        = 2;
  // Link register field.
  localparam int LNK_MISMATCH = 7;
  // Reset values.
  localparam logic       RST_TEST_ACTIVE = 1'b0;
  localparam logic       RST_RESET_OCC   = 1'b1;
  localparam logic       RST_INIT        = 1'b1;
  localparam logic [4:0] RST_SUPPLY      = 5'h00;
  localparam logic [7:0] RST_BYTE        = 8'h00;
  // Timing.
  localparam int unsigned CLK_PERIOD_NS           = 5;
  localparam int unsigned DATA_VALID_TIME_NS      = 100000;
  localparam int unsigned SUPPLY_RECOVERY_TIME_NS = 10000;
  localparam int          TIMER_W                 = 24;

  typedef struct packed {
    logic selftest_incomplete;
    logic common_mode_fault;
    logic selftest_fault;
    logic serial_mismatch;
    logic factory_otp_fault;
    logic user_otp_fault;
    logic user_array_fault;
    logic otp_write_active;
    logic temperature_fault;
    logic supply_undervoltage;
    logic analog_regulator_fault;
    logic digital_regulator_fault;
    logic otp_regulator_fault;
    logic edge_seal_fault;
  } sdfb_src_t;

  typedef struct packed {
    logic reset_occurred;
    logic memory;
    logic link;
  } sdfb_txclr_t;

  // A least time rounds up and never falls below one cycle.
  function automatic int unsigned sdfb_cycles_ceil(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction : sdfb_cycles_ceil
endpackage : sdfb_pkg

// [src/sdfb_countdown.sv]
// Reloadable down-counter that flags when its interval has run out.
module sdfb_countdown
  import sdfb_pkg::*;
#(
  parameter int               CNT_W = TIMER_W,
  parameter logic [CNT_W-1:0] LOAD  = '1
) (
  // Clock and reset
  input  wire  logic clk,
  input  wire  logic rst,
  // Control
  input  wire  logic reload,
  // Status
  output logic       expired
);
  logic [CNT_W-1:0] count_reg;

  // The interval restarts on reset so a fresh power-up always waits in full.
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= LOAD;
    end else if (reload) begin
      count_reg <= LOAD;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign expired = (count_reg == '0);
endmodule : sdfb_countdown

// [src/sdfb_status_bank.sv]
// Device status flag bank: summary, supply, memory and link status registers.
module sdfb_status_bank
  import sdfb_pkg::*;
#(
  parameter int unsigned DATA_VALID_TIME_NS_P      = DATA_VALID_TIME_NS,
  parameter int unsigned SUPPLY_RECOVERY_TIME_NS_P = SUPPLY_RECOVERY_TIME_NS
) (
  // Clock and reset
  input  wire  logic        clk,
  input  wire  logic        rst,
  // Source monitors
  input  wire  sdfb_src_t   src,
  // Test mode operations
  input  wire  logic        test_enter,
  input  wire  logic        test_exit,
  // Supply reporting control
  input  wire  logic        power_fault_report_disable,
  // Register reads from the serial front end
  input  wire  logic        rd_en,
  input  wire  logic [7:0]  rd_addr,
  input  wire  sdfb_txclr_t tx_clear,
  // Read answer and status field
  output logic              rd_valid,
  output logic [7:0]        rd_data,
  output logic [7:0]        status_summary
);
  localparam int unsigned DV_CYC  = sdfb_cycles_ceil(DATA_VALID_TIME_NS_P);
  localparam int unsigned REC_CYC = sdfb_cycles_ceil(SUPPLY_RECOVERY_TIME_NS_P);

  logic       test_active_reg;
  logic       reset_occurred_reg;
  logic       init_reg;
  logic [4:0] supply_reg;
  logic [7:0] memory_reg;
  logic       link_reg;
  logic [7:0] rd_data_reg;
  logic       rd_valid_reg;
  logic [7:0] summary_reg;
  logic [7:0] summary_next;
  logic [4:0] supply_raw;
  logic       supply_any;
  logic       supply_expired;
  logic       init_expired;
  logic       rd_summary;
  logic       rd_supply;
  logic       rd_memory;
  logic       rd_link;

  function automatic logic addr_hit(input logic en, input logic [7:0] a, input logic [7:0] target);
    return en && (a == target);
  endfunction : addr_hit

  assign rd_summary = addr_hit(rd_en, rd_addr, ADDR_SUMMARY);
  assign rd_supply  = addr_hit(rd_en, rd_addr, ADDR_SUPPLY);
  assign rd_memory  = addr_hit(rd_en, rd_addr, ADDR_MEMORY);
  assign rd_link    = addr_hit(rd_en, rd_addr, ADDR_LINK);

  // Raw supply monitor levels in supply register order.
  assign supply_raw = {src.analog_regulator_fault, src.digital_regulator_fault,
                       src.otp_regulator_fault, src.edge_seal_fault, 1'b0};
  assign supply_any = (supply_raw != '0) || src.supply_undervoltage;

  // Init lasts the data-valid time rounded up to whole cycles, plus one cycle, after any reset.
  sdfb_countdown #(
    .CNT_W (TIMER_W),
    .LOAD  (DV_CYC[TIMER_W-1:0])
  ) u_init_timer (
    .clk     (clk),
    .rst     (rst),
    .reload  (1'b0),
    .expired (init_expired)
  );

  // One timer for every supply flag; any live fault restarts it.
  sdfb_countdown #(
    .CNT_W (TIMER_W),
    .LOAD  (REC_CYC[TIMER_W-1:0])
  ) u_supply_timer (
    .clk     (clk),
    .rst     (rst),
    .reload  (supply_any),
    .expired (supply_expired)
  );

  // Test flag: only a test-mode operation or a power cycle moves it.
  always_ff @(posedge clk) begin
    if (rst) begin
      test_active_reg <= RST_TEST_ACTIVE;
    end else if (test_enter) begin
      test_active_reg <= 1'b1;
    end else if (test_exit) begin
      test_active_reg <= 1'b0;
    end
  end

  // Reset flag: set by reset itself, so a clear can never race a set.
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_occurred_reg <= RST_RESET_OCC;
    end else if (rd_summary || tx_clear.reset_occurred) begin
      reset_occurred_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      init_reg <= RST_INIT;
    end else if (init_expired) begin
      init_reg <= 1'b0;
    end
  end

  // Supply flags latch the raw monitors. With reporting enabled they fall by
  // themselves once the shared timer runs out; with reporting disabled they are
  // kept until software reads them after recovery, so a glitch is not missed.
  always_ff @(posedge clk) begin
    if (rst) begin
      supply_reg <= RST_SUPPLY;
    end else if (supply_any) begin
      supply_reg <= supply_reg | {src.supply_undervoltage, supply_raw[4:1]};
    end else if (supply_expired && (!power_fault_report_disable || rd_supply)) begin
      supply_reg <= '0;
    end
  end

  // Memory flags: sticky events, the write-active bit is a plain level.
  always_ff @(posedge clk) begin
    if (rst) begin
      memory_reg <= RST_BYTE;
    end else begin
      for (int i = 0; i < 8; i++) begin
        memory_reg[i] <= 1'b0;
      end
      memory_reg[MEM_FACTORY_OTP] <= src.factory_otp_fault ||
                                     (memory_reg[MEM_FACTORY_OTP] && !(rd_memory || tx_clear.memory));
      memory_reg[MEM_USER_OTP]    <= src.user_otp_fault ||
                                     (memory_reg[MEM_USER_OTP] && !(rd_memory || tx_clear.memory));
      memory_reg[MEM_USER_ARRAY]  <= src.user_array_fault ||
                                     (memory_reg[MEM_USER_ARRAY] && !(rd_memory || tx_clear.memory));
      memory_reg[MEM_TEMP]        <= src.temperature_fault ||
                                     (memory_reg[MEM_TEMP] && !(rd_memory || tx_clear.memory));
      memory_reg[MEM_WRITE_ACT]   <= src.otp_write_active;
    end
  end

  // Mismatch flag: a fault in the clearing cycle still sets it.
  always_ff @(posedge clk) begin
    if (rst) begin
      link_reg <= 1'b0;
    end else begin
      link_reg <= src.serial_mismatch || (link_reg && !(rd_link || tx_clear.link));
    end
  end

  // Summary is combined afresh every cycle; a summary read clears only the reset flag among its sources.
  always_comb begin
    summary_next              = RST_BYTE;
    summary_next[SUM_SIGPROC] = src.selftest_incomplete || src.common_mode_fault ||
                                src.selftest_fault;
    summary_next[SUM_LINK]    = link_reg;
    summary_next[SUM_MEMTEMP] = memory_reg[MEM_FACTORY_OTP] || memory_reg[MEM_USER_OTP] ||
                                memory_reg[MEM_USER_ARRAY] || memory_reg[MEM_WRITE_ACT] ||
                                memory_reg[MEM_TEMP];
    summary_next[SUM_SUPPLY]  = supply_reg != '0;
    summary_next[SUM_TEST]    = test_active_reg;
    summary_next[SUM_RESET]   = reset_occurred_reg;
    summary_next[SUM_INIT]    = init_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      summary_reg <= RST_BYTE;
    end else begin
      summary_reg <= summary_next;
    end
  end

  // Read answers carry the values from before any clear-on-read.
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= RST_BYTE;
    end else begin
      rd_valid_reg <= rd_en;
      if (rd_en) begin
        case (rd_addr)
          ADDR_SUMMARY: rd_data_reg <= summary_next;
          ADDR_SUPPLY:  rd_data_reg <= {supply_reg[4], 3'b000, supply_reg[3:0]};
          ADDR_MEMORY:  rd_data_reg <= memory_reg;
          ADDR_LINK:    rd_data_reg <= {link_reg, 7'h00};
          default:      rd_data_reg <= RST_BYTE;
        endcase
      end
    end
  end

  assign rd_valid       = rd_valid_reg;
  assign rd_data        = rd_data_reg;
  assign status_summary = summary_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_summary_read;
    rd_en && (rd_addr == ADDR_SUMMARY);
  endsequence

  sequence s_supply_quiet;
    !supply_any [*2];
  endsequence

  chk_read_answer_next: assert property (rd_en |=> rd_valid && $past(rd_en))
    else $error("Read answer missing one cycle after request.");

  chk_summary_read_data: assert property (s_summary_read |=> rd_data == $past(summary_next))
    else $error("Summary read data does not match summary value.");

  chk_sigproc_or: assert property (
    (src.selftest_incomplete || src.common_mode_fault || src.selftest_fault) |=> status_summary[SUM_SIGPROC])
    else $error("Signal processor fault not reported.");

  chk_link_in_summary: assert property (src.serial_mismatch |=> ##1 status_summary[SUM_LINK])
    else $error("Link fault missing from summary after mismatch.");

  chk_memtemp_in_summary: assert property (src.temperature_fault |=> ##1 status_summary[SUM_MEMTEMP])
    else $error("Memory fault missing from summary after temperature fault.");

  chk_supply_in_summary: assert property (src.edge_seal_fault |=> ##1 status_summary[SUM_SUPPLY])
    else $error("Supply fault missing from summary after seal fault.");

  chk_test_read_keeps: assert property (
    s_summary_read and (test_active_reg && !test_exit) |=> test_active_reg)
    else $error("Test flag cleared by a read.");

  chk_reset_read_clears: assert property (s_summary_read |=> ##1 !status_summary[SUM_RESET])
    else $error("Reset flag survived a summary read.");

  chk_init_clear: assert property (init_reg && init_expired |=> !init_reg ##1 !status_summary[SUM_INIT])
    else $error("Init flag did not clear at data-valid time.");

  chk_seal_reset_zero: assert property ($fell(rst) |-> supply_reg[SUP_SEAL] == 1'b0)
    else $error("Continuity flag not zero after reset.");

  chk_supply_reload: assert property (supply_any |=> !supply_expired)
    else $error("Recovery timer not reloaded by supply fault.");

  chk_supply_held: assert property (
    (power_fault_report_disable && supply_reg != '0 && !rd_supply) |=> supply_reg != '0)
    else $error("Supply flags cleared without a read while reporting disabled.");

  chk_supply_autoclr: assert property (
    s_supply_quiet ##0 (supply_expired && !power_fault_report_disable) |=> supply_reg == '0)
    else $error("Supply flags not cleared after recovery.");

  chk_undervolt_set: assert property (src.supply_undervoltage |=> supply_reg[4])
    else $error("Undervoltage flag not set.");

  chk_regulator_set: assert property (src.analog_regulator_fault |=> supply_reg[SUP_ANALOG])
    else $error("Analog regulator flag not set.");

  chk_memory_read_clears: assert property (
    rd_memory && !src.temperature_fault |=> !memory_reg[MEM_TEMP])
    else $error("Temperature flag survived a memory read.");

  chk_memory_set_wins: assert property (
    (src.user_otp_fault && (rd_memory || tx_clear.memory)) |=> memory_reg[MEM_USER_OTP])
    else $error("User OTP fault lost in clearing cycle.");

  chk_write_active_fall: assert property ($fell(src.otp_write_active) |=> !memory_reg[MEM_WRITE_ACT])
    else $error("Write-active flag not cleared after write ended.");

  chk_mismatch_set_wins: assert property ((src.serial_mismatch && rd_link) |=> link_reg)
    else $error("Mismatch lost in clearing cycle.");

  chk_reserved_zero: assert property (
    s_summary_read |=> rd_data[6] == 1'b0)
    else $error("Reserved summary bit read as one.");

  chk_summary_no_side: assert property (
    (s_summary_read and link_reg && !tx_clear.link && !rd_link) |=> link_reg)
    else $error("Summary read cleared a source flag.");
endmodule : sdfb_status_bank

// [test/sdfb_host_model.sv]
// Host controller model that issues status register reads to the flag bank.
module sdfb_host_model (
  // Clock and reset
  input  wire  logic       clk,
  input  wire  logic       rst,
  // Read request
  output logic             rd_en,
  output logic [7:0]       rd_addr
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    rd_en   = 1'b0;
    rd_addr = 8'h00;
  end

  // Reads are held back for up to 16 cycles while the device sits in reset, so supply flags seen then are never used.
  task automatic rd(input logic [7:0] a);
    for (int k = 0; k < 16 && rst; k++) begin
      @(posedge clk);
      #1;
    end
    rd_en   = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #1;
  endtask : rd

  // A released address shows the inverse of its last value, so a stale address cannot pass.
  task automatic idle(input int n);
    rd_en   = 1'b0;
    rd_addr = ~rd_addr;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
endmodule : sdfb_host_model

// [test/sdfb_status_bank_test.sv]
// Self-checking testbench for the device status flag bank.
module sdfb_status_bank_test
  import sdfb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rst;
  sdfb_src_t   src;
  logic        test_enter;
  logic        test_exit;
  logic        power_fault_report_disable;
  sdfb_txclr_t tx_clear;
  wire logic   rd_en;
  wire logic [7:0] rd_addr;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic [7:0]  status_summary;
  logic [15:0] expq [$];
  logic [15:0] note;
  logic [31:0] lfsr;
  int          n_errors;
  int          checks_done;
  logic [13:0] mem_src [4] = '{14'h0200, 14'h0100, 14'h0080, 14'h0020};
  logic [7:0]  mem_exp [4] = '{8'h80, 8'h40, 8'h20, 8'h04};
  logic [13:0] sup_src [5] = '{14'h0010, 14'h0008, 14'h0004, 14'h0002, 14'h0001};
  logic [7:0]  sup_exp [5] = '{8'h80, 8'h08, 8'h04, 8'h02, 8'h01};

  sdfb_status_bank #(.DATA_VALID_TIME_NS_P(50), .SUPPLY_RECOVERY_TIME_NS_P(40)) dut (
    .clk(clk), .rst(rst), .src(src), .test_enter(test_enter), .test_exit(test_exit),
    .power_fault_report_disable(power_fault_report_disable), .rd_en(rd_en), .rd_addr(rd_addr),
    .tx_clear(tx_clear), .rd_valid(rd_valid), .rd_data(rd_data), .status_summary(status_summary));

  sdfb_host_model host (.clk(clk), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // The expected answer is noted first; the watcher below takes it when the answer shows.
  task automatic ex(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({a, e});
    host.rd(a);
  endtask : ex

  task automatic pulse_src(input logic [13:0] v);
    src = sdfb_src_t'(v);
    host.idle(1);
    src = sdfb_src_t'(14'h0000);
    host.idle(2);
  endtask : pulse_src

  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0) check("rd_valid", 8'h01, 8'h00);
      else begin
        note = expq.pop_front();
        check($sformatf("rd_data at %h", note[15:8]), rd_data, note[7:0]);
      end
    end
  end

  // The run is cut short here if the main sequence ever hangs.
  initial begin
    for (int k = 0; k < 100000; k++) @(posedge clk);
    n_errors++;
    $display("MISMATCH run_length expected finish seen timeout");
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    src = sdfb_src_t'(14'h0000);
    test_enter = 1'b0;
    test_exit = 1'b0;
    power_fault_report_disable = 1'b0;
    tx_clear = sdfb_txclr_t'(3'b000);
    lfsr = 32'h5ae18163;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    ex(8'h01, 8'h03);
    ex(8'h01, 8'h01);
    ex(8'h02, 8'h00);
    ex(8'h05, 8'h00);
    ex(8'h01, 8'h01);
    host.idle(7);
    ex(8'h01, 8'h00);
    host.idle(2);
    check("status_summary", status_summary, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      src = sdfb_src_t'({lfsr[2:0], 11'h000});
      ex(8'h01, {|lfsr[2:0], 7'h00});
    end
    src = sdfb_src_t'(14'h0800);
    host.idle(1);
    check("status_summary", status_summary, 8'h80);
    src = sdfb_src_t'(14'h0000);
    host.idle(2);
    $display("test sigproc done");
    pulse_src(14'h0400);
    ex(8'h01, 8'h20);
    ex(8'h04, 8'h80);
    ex(8'h04, 8'h00);
    host.idle(2);
    ex(8'h01, 8'h00);
    pulse_src(14'h0400);
    tx_clear = sdfb_txclr_t'(3'b001);
    host.idle(1);
    tx_clear = sdfb_txclr_t'(3'b000);
    host.idle(2);
    ex(8'h04, 8'h00);
    $display("test link done");
    for (int i = 0; i < 4; i++) begin
      pulse_src(mem_src[i]);
      ex(8'h01, 8'h10);
      ex(8'h03, mem_exp[i]);
      host.idle(2);
      ex(8'h03, 8'h00);
      ex(8'h01, 8'h00);
    end
    src = sdfb_src_t'(14'h0040);
    host.idle(2);
    ex(8'h03, 8'h10);
    ex(8'h03, 8'h10);
    ex(8'h01, 8'h10);
    src = sdfb_src_t'(14'h0000);
    host.idle(2);
    ex(8'h03, 8'h00);
    pulse_src(14'h0020);
    tx_clear = sdfb_txclr_t'(3'b010);
    host.idle(1);
    tx_clear = sdfb_txclr_t'(3'b000);
    host.idle(2);
    ex(8'h03, 8'h00);
    $display("test memory done");
    for (int i = 0; i < 5; i++) begin
      src = sdfb_src_t'(sup_src[i]);
      host.idle(3);
      ex(8'h01, 8'h08);
      ex(8'h02, sup_exp[i]);
      src = sdfb_src_t'(14'h0000);
      host.idle(4);
      ex(8'h02, sup_exp[i]);
      host.idle(10);
      ex(8'h02, 8'h00);
      ex(8'h01, 8'h00);
    end
    power_fault_report_disable = 1'b1;
    src = sdfb_src_t'(14'h0010);
    host.idle(1);
    src = sdfb_src_t'(14'h0000);
    host.idle(12);
    ex(8'h02, 8'h80);
    ex(8'h02, 8'h00);
    power_fault_report_disable = 1'b0;
    host.idle(2);
    ex(8'h01, 8'h00);
    $display("test supply done");
    for (int i = 0; i < 2; i++) begin
      test_enter = 1'b1;
      test_exit = (i == 1);
      host.idle(1);
      test_enter = 1'b0;
      test_exit = 1'b0;
      host.idle(2);
      ex(8'h01, 8'h04);
      ex(8'h01, 8'h04);
      check("status_summary", status_summary, 8'h04);
      test_exit = 1'b1;
      host.idle(1);
      test_exit = 1'b0;
      host.idle(2);
      ex(8'h01, 8'h00);
    end
    $display("test mode done");
    // Random faults on every link, memory and supply source, with a racing transmission clear.
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      src = sdfb_src_t'({3'b000, lfsr[10:0]});
      tx_clear = sdfb_txclr_t'(lfsr[13:11]);
      host.idle(1);
      src = sdfb_src_t'(14'h0000);
      tx_clear = sdfb_txclr_t'(3'b000);
      host.idle(2);
      ex(8'h01, {2'b00, lfsr[10], |{lfsr[9:7], lfsr[5]}, |lfsr[4:0], 3'b000});
      ex(8'h03, {lfsr[9:7], 2'b00, lfsr[5], 2'b00});
      ex(8'h04, {lfsr[10], 7'h00});
      ex(8'h02, {lfsr[4], 3'b000, lfsr[3:0]});
      host.idle(12);
      ex(8'h01, 8'h00);
      host.idle(1);
    end
    $display("test random done");
    rst = 1'b1;
    host.idle(1);
    rst = 1'b0;
    tx_clear = sdfb_txclr_t'(3'b100);
    host.idle(1);
    tx_clear = sdfb_txclr_t'(3'b000);
    host.idle(2);
    ex(8'h01, 8'h01);
    host.idle(1);
    $display("test second reset done");
    for (int k = 0; k < 8 && expq.size() != 0; k++) @(posedge clk);
    check("pending reads", 8'(expq.size()), 8'h00);
    tally_and_finish();
  end
endmodule : sdfb_status_bank_test
